// ==== rtl/brs_sequencer.sv ====
// Brown-out and power-up reset sequencer with its register port
`include "brs_params.svh"
`default_nettype none

module brs_sequencer #(
    parameter int unsigned STARTUP_CYC = `BRS_STARTUP_CYC,
    parameter int unsigned FIXED_CYC   = `BRS_FIXED_CYC,
    parameter int unsigned POWERUP_TIMER_CYC    = `BRS_POWERUP_TIMER_CYC,
    parameter int unsigned OST_CYC     = `BRS_OST_CYC
) (
    // Clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // Supply monitor and clock partners (asynchronous)
    input  wire logic               brownout_det,
    input  wire logic               powered_down,
    input  wire logic               pll_locked,
    // Register port
    input  wire brs_pkg::brs_addr_t reg_addr,
    input  wire brs_pkg::brs_word_t reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output var  brs_pkg::brs_word_t reg_rdata,
    // Reset and clock controls
    output logic                    bor_pulse,
    output logic                    core_rst_n,
    output logic                    sys_clk_en
);
    import brs_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       det_prev_q;
    logic       det_s;
    logic       pdn_s;
    logic       lock_s;

    // Two flops per pin before any logic looks at it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= {pll_locked, powered_down, brownout_det};
            sync_q <= meta_q;
        end
    end

    assign det_s  = sync_q[0];
    assign pdn_s  = sync_q[1];
    assign lock_s = sync_q[2];

    // Edge memory reads only the settled copy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            det_prev_q <= 1'b0;
        end else begin
            det_prev_q <= det_s;
        end
    end

    // ---------------------------------------------------------------
    // Event decode
    // ---------------------------------------------------------------
    logic bor_evt;

    // Power-down gating: detector edges are ignored while powered down
    assign bor_evt = det_s && !det_prev_q && !pdn_s;

    // ---------------------------------------------------------------
    // Configuration register and clock source choice
    // ---------------------------------------------------------------
    localparam int unsigned CW = `BRS_CFG_CFG_W;

    logic [CW-1:0] cfg_q;
    logic [CW-1:0] act_q;
    logic          need_ost;
    logic          need_pll;
    logic          fixed_mode;
    logic          pri_xtal;

    logic wr_cfg;
    assign wr_cfg = reg_wr && (reg_addr == `BRS_REG_CFG);

    // Software settings take effect at the next sequence only
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cfg_q <= CW'(`BRS_CFG_RST);
        end else if (wr_cfg) begin
            cfg_q <= reg_wdata[CW-1:0];
        end
    end

    // Crystal primary: selected and neither external clock nor off
    assign pri_xtal = act_q[`BRS_OSC_PRI_BIT]
                   && (act_q[4:3] != `BRS_PRI_EC)
                   && (act_q[4:3] != `BRS_PRI_OFF);
    assign need_ost   = pri_xtal;
    assign need_pll   = act_q[`BRS_OSC_PLL_BIT];
    assign fixed_mode = !act_q[`BRS_CFG_POWERUP_TIMER_EN] && pri_xtal;

    // ---------------------------------------------------------------
    // Sequencer state and delay counter
    // ---------------------------------------------------------------
    localparam logic [15:0] STARTUP_LAST = 16'(STARTUP_CYC - 1);
    localparam logic [15:0] FIXED_LAST   = 16'(FIXED_CYC - 1);
    localparam logic [15:0] POWERUP_TIMER_LAST    = 16'(POWERUP_TIMER_CYC - 1);
    localparam logic [15:0] OST_LAST     = 16'(OST_CYC - 1);
    localparam logic [15:0] PULSE_LAST   = 16'(`BRS_PULSE_CYC - 1);

    brs_state_t  st_q;
    logic [15:0] dly_q;
    logic [15:0] ost_q;
    logic        ost_done;
    logic        powerup_timer_done;
    logic        fixed_done;
    logic        clk_ok;
    logic        rel_ok;

    assign ost_done   = (ost_q >= OST_LAST);
    assign powerup_timer_done  = !act_q[`BRS_CFG_POWERUP_TIMER_EN] || (dly_q >= POWERUP_TIMER_LAST);
    assign fixed_done = (dly_q >= FIXED_LAST);
    assign clk_ok     = (!need_ost || ost_done) && (!need_pll || lock_s);
    // Fixed delay replaces every other wait; else timer and clock
    assign rel_ok = fixed_mode ? fixed_done : (powerup_timer_done && clk_ok);

    // Main sequence; power-down beats brown-out beats progress
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q  <= BRS_STARTUP;
            dly_q <= 16'h0000;
            act_q <= CW'(`BRS_CFG_RST);
        end else if (pdn_s) begin
            st_q  <= BRS_STARTUP;
            dly_q <= 16'h0000;
        end else if (bor_evt) begin
            st_q  <= BRS_PULSE;
            dly_q <= 16'h0000;
        end else begin
            case (st_q)
                BRS_STARTUP: begin
                    if (dly_q >= STARTUP_LAST) begin
                        st_q  <= BRS_HOLD;
                        dly_q <= 16'h0000;
                        act_q <= cfg_q;
                    end else begin
                        dly_q <= dly_q + 16'h0001;
                    end
                end
                BRS_PULSE: begin
                    if (dly_q >= PULSE_LAST) begin
                        st_q  <= BRS_HOLD;
                        dly_q <= 16'h0000;
                        act_q <= cfg_q;
                    end else begin
                        dly_q <= dly_q + 16'h0001;
                    end
                end
                BRS_HOLD: begin
                    if (rel_ok) begin
                        st_q <= BRS_RUN;
                    end else if (dly_q != 16'hFFFF) begin
                        dly_q <= dly_q + 16'h0001;
                    end
                end
                BRS_RUN: begin
                    st_q <= BRS_RUN;
                end
                default: begin
                    st_q  <= BRS_STARTUP;
                    dly_q <= 16'h0000;
                end
            endcase
        end
    end

    // Start-up timer runs only in hold and only for a crystal
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ost_q <= 16'h0000;
        end else if (st_q != BRS_HOLD || !need_ost) begin
            ost_q <= 16'h0000;
        end else if (!ost_done) begin
            ost_q <= ost_q + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // Reset and clock outputs, one cycle behind the state
    // ---------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bor_pulse  <= 1'b0;
            core_rst_n <= 1'b0;
            sys_clk_en <= 1'b0;
        end else begin
            bor_pulse  <= (st_q == BRS_PULSE);
            core_rst_n <= (st_q == BRS_RUN);
            sys_clk_en <= (st_q == BRS_RUN)
                       || (st_q == BRS_HOLD && clk_ok);
        end
    end

    // ---------------------------------------------------------------
    // Reset cause register
    // ---------------------------------------------------------------
    logic por_q;
    logic bor_flag_q;
    logic wr_cause;

    assign wr_cause = reg_wr && (reg_addr == `BRS_REG_CAUSE);

    // Written ones clear; a new brown-out in the same cycle wins.
    // Only rst_n and a written one clear it, never the brown-out pulse it reports.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bor_flag_q <= 1'b0;
        end else if (bor_evt) begin
            bor_flag_q <= 1'b1;
        end else if (wr_cause && reg_wdata[`BRS_CAUSE_BOR]) begin
            bor_flag_q <= 1'b0;
        end
    end

    // Power-on flag marks the block's own reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            por_q <= 1'b1;
        end else if (wr_cause && reg_wdata[`BRS_CAUSE_POR]) begin
            por_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Read port: data in the cycle after the strobe
    // ---------------------------------------------------------------
    brs_word_t rd_mux;

    always_comb begin
        rd_mux = 16'h0000;
        case (reg_addr)
            `BRS_REG_CAUSE: begin
                rd_mux[`BRS_CAUSE_POR] = por_q;
                rd_mux[`BRS_CAUSE_BOR] = bor_flag_q;
            end
            `BRS_REG_OSC: begin
                rd_mux[2:0]              = act_q[2:0];
                rd_mux[`BRS_OSC_OSTDONE] = ost_done;
                rd_mux[`BRS_OSC_CLKEN]   = sys_clk_en;
                rd_mux[`BRS_OSC_LOCK]    = lock_s;
            end
            `BRS_REG_CFG: begin
                rd_mux[CW-1:0] = cfg_q;
            end
            default: begin
                rd_mux = 16'h0000;
            end
        endcase
    end

    // Unmapped or idle reads return zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    int unsigned stup_cnt;

    // Cycles spent in start-up without a power-down
    always_ff @(posedge mclk) begin
        if (!rst_n || st_q != BRS_STARTUP || pdn_s) begin
            stup_cnt <= 0;
        end else begin
            stup_cnt <= stup_cnt + 1;
        end
    end

    sequence s_bor_seen;
        bor_evt && !pdn_s;
    endsequence

    sequence s_pulse_out;
        ##1 (st_q == BRS_PULSE) ##1 bor_pulse && !core_rst_n;
    endsequence

    a_startup_len: assert property (
        (st_q == BRS_STARTUP)
        |-> (stup_cnt < STARTUP_CYC))
        else $error("start-up hold overran");

    a_startup_exit: assert property (
        (st_q == BRS_STARTUP) ##1 (st_q == BRS_HOLD)
        |-> $past(stup_cnt) == STARTUP_CYC - 1 && !core_rst_n)
        else $error("start-up left early or late");

    a_pdn_restart: assert property (
        pdn_s |=> (st_q == BRS_STARTUP) ##1 !core_rst_n)
        else $error("power-down did not restart hold-off");

    a_bor_pulse: assert property (
        s_bor_seen |-> s_pulse_out)
        else $error("brown-out gave no reset pulse");

    a_cfg_latch: assert property (
        (st_q == BRS_PULSE) ##1 (st_q == BRS_HOLD) |-> act_q == $past(cfg_q))
        else $error("clock source not taken from settings");

    a_ost_hold: assert property (
        (st_q == BRS_HOLD) && need_ost && !ost_done |=> !sys_clk_en)
        else $error("clock ran before start-up timer");

    a_pll_hold: assert property (
        (st_q == BRS_HOLD) && need_pll && !lock_s |=> !sys_clk_en)
        else $error("clock ran before lock");

    a_powerup_timer_hold: assert property (
        (st_q == BRS_HOLD) && !fixed_mode && !powerup_timer_done |=> !core_rst_n)
        else $error("reset released before power-up timer");

    a_fixed_delay: assert property (
        (st_q == BRS_HOLD) && fixed_mode && rel_ok && !pdn_s && !bor_evt
        |-> (dly_q == FIXED_LAST)
            ##1 (st_q == BRS_RUN))
        else $error("fixed crystal delay not applied");

    a_flag_set: assert property (
        s_bor_seen |=> bor_flag_q [*2])
        else $error("brown-out flag not set");

    a_flag_keep: assert property (
        bor_flag_q && !(wr_cause && reg_wdata[`BRS_CAUSE_BOR]) |=> bor_flag_q)
        else $error("brown-out flag lost without clear");

    a_live_run: assert property (
        (st_q == BRS_RUN) && bor_evt |=> $fell(st_q == BRS_RUN))
        else $error("detector ignored brown-out while running");

endmodule : brs_sequencer

`default_nettype wire

// ==== rtl/brs_params.svh ====
// Offsets, field positions, reset values and timing counts of the sequencer
`ifndef BRS_PARAMS_SVH
`define BRS_PARAMS_SVH

// ---------------------------------------------------------------------
// Register offsets (word index on the register port)
// ---------------------------------------------------------------------
`define BRS_REG_CAUSE      4'h0
`define BRS_REG_OSC        4'h1
`define BRS_REG_CFG        4'h2

// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define BRS_CAUSE_POR      0
`define BRS_CAUSE_BOR      1
`define BRS_OSC_LOCK       5
`define BRS_OSC_CLKEN      4
`define BRS_OSC_OSTDONE    3
`define BRS_CFG_POWERUP_TIMER_EN    5
`define BRS_CFG_CFG_W      6

// ---------------------------------------------------------------------
// Reset values and clock source encodings
// ---------------------------------------------------------------------
`define BRS_CFG_RST        16'h0000
`define BRS_OSC_PLL_BIT    0
`define BRS_OSC_PRI_BIT    1
`define BRS_PRI_EC         2'h0
`define BRS_PRI_OFF        2'h3

// ---------------------------------------------------------------------
// Timing: start-up and fixed times in microseconds, derived to cycles from the clock; other counts in cycles
// ---------------------------------------------------------------------
`define BRS_CLK_MHZ        100
`define BRS_STARTUP_US     20
`define BRS_STARTUP_CYC    (`BRS_STARTUP_US * `BRS_CLK_MHZ)
`define BRS_FIXED_US       100
`define BRS_FIXED_CYC      (`BRS_FIXED_US * `BRS_CLK_MHZ)
`define BRS_POWERUP_TIMER_CYC       1000
`define BRS_OST_CYC        1024
`define BRS_PULSE_CYC      16

`endif

// ==== rtl/brs_pkg.sv ====
// Types shared by the brown-out reset sequencer
`default_nettype none

package brs_pkg;

    // Sequencer states, Gray coded along startup -> pulse -> hold -> run
    typedef enum logic [1:0] {
        BRS_STARTUP = 2'h0,
        BRS_PULSE   = 2'h1,
        BRS_HOLD    = 2'h3,
        BRS_RUN     = 2'h2
    } brs_state_t;

    typedef logic [15:0] brs_word_t;
    typedef logic [3:0]  brs_addr_t;

endpackage : brs_pkg

`default_nettype wire

// ==== tb/brs_partner.sv ====
// PLL model on the far side of the sequencer
`default_nettype none

module brs_partner #(
    parameter int unsigned LOCK_CYC = 60
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // Device reset pulse from the sequencer
    input  wire logic bor_pulse,
    // Lock indication back to the sequencer
    output var  logic pll_locked
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned cnt_q;

    // Relock counter: a device reset upsets the loop, so lock is lost
    always_ff @(posedge mclk) begin
        if (!rst_n || bor_pulse) begin
            cnt_q <= 0;
        end else if (cnt_q < LOCK_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end

    // Lock comes late on purpose, so a clock hold on it shows
    assign pll_locked = (cnt_q >= LOCK_CYC);

endmodule : brs_partner

`default_nettype wire

// ==== tb/tb_brs_sequencer.sv ====
// Self-checking bench for the brown-out reset sequencer
`include "brs_params.svh"
`default_nettype none

module tb_brs_sequencer;
    import brs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // ---------------------------------------------------------------
    // Signals and shortened counts
    // ---------------------------------------------------------------
    localparam int STARTUP = 20;
    localparam int FIXED   = 40;
    localparam int POWERUP_TIMER    = 30;
    localparam int OSC_STARTUP_TIMER     = 10;
    localparam int LOCK    = 60;
    localparam int BP      = 0;
    localparam int CR      = 1;
    localparam int SC      = 2;

    logic      mclk;
    logic      rst_n;
    logic      brownout_det;
    logic      powered_down;
    logic      pll_locked;
    brs_addr_t reg_addr;
    brs_word_t reg_wdata;
    logic      reg_wr;
    logic      reg_rd;
    brs_word_t reg_rdata;
    logic      bor_pulse;
    logic      core_rst_n;
    logic      sys_clk_en;
    int        fails;
    int        total_checks;
    int        n;
    int        m;
    brs_word_t d;

    brs_sequencer #(
        .STARTUP_CYC(STARTUP), .FIXED_CYC(FIXED), .POWERUP_TIMER_CYC(POWERUP_TIMER), .OST_CYC(OSC_STARTUP_TIMER)
    ) brs_sequencer_inst (
        .mclk(mclk), .rst_n(rst_n), .brownout_det(brownout_det),
        .powered_down(powered_down), .pll_locked(pll_locked),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bor_pulse(bor_pulse),
        .core_rst_n(core_rst_n), .sys_clk_en(sys_clk_en)
    );

    brs_partner #(.LOCK_CYC(LOCK)) brs_partner_inst (
        .mclk(mclk), .rst_n(rst_n), .bor_pulse(bor_pulse), .pll_locked(pll_locked)
    );

    // Clock at 100 MHz
    always #5 mclk = ~mclk;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic sig(input int k);
        case (k)
            BP:      return bor_pulse;
            CR:      return core_rst_n;
            default: return sys_clk_en;
        endcase
    endfunction : sig

    function automatic brs_word_t b(input logic x);
        return {15'h0000, x};
    endfunction : b

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input brs_word_t seen, input brs_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Bounded wait; a miss only counts when the level must appear
    task automatic wait_sig(input int k, input logic v, input int lim, input bit must,
                            output int cnt);
        cnt = 0;
        while (sig(k) !== v && cnt < lim) begin
            @(posedge mclk);
            #1;
            cnt++;
        end
        if (must && sig(k) !== v) begin
            fails++;
            $display("ERROR %0t wait ran out", $time);
            end_sim();
        end
    endtask : wait_sig

    task automatic wr(input brs_addr_t a, input brs_word_t v);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input brs_addr_t a, output brs_word_t v);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // Raise the detector, measure the reset pulse it causes
    task automatic brownout(output int len);
        int k;
        @(posedge mclk);
        brownout_det <= 1'b1;
        wait_sig(BP, 1'b1, 10, 1'b1, k);
        check(b(core_rst_n), 16'h0000);
        check(b(sys_clk_en), 16'h0000);
        brownout_det <= 1'b0;
        wait_sig(BP, 1'b0, 40, 1'b1, len);
        check(b(len == `BRS_PULSE_CYC), 16'h0001);
    endtask : brownout

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        mclk = 0; rst_n = 0; brownout_det = 0; powered_down = 0;
        reg_addr = '0; reg_wdata = '0; reg_wr = 0; reg_rd = 0;
        fails = 0; total_checks = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        // Start-up hold after power-on
        wait_sig(CR, 1'b1, 200, 1'b1, n);
        check(b(n >= STARTUP && n <= STARTUP + 8), 16'h0001);
        rd(`BRS_REG_CAUSE, d);
        check(d, 16'h0001);
        rd(`BRS_REG_CFG, d);
        check(d, `BRS_CFG_RST);
        rd(4'h7, d);
        check(d, 16'h0000);
        // Crystal, power-up timer off: fixed delay only
        wr(`BRS_REG_CFG, 16'hFFCA);
        rd(`BRS_REG_CFG, d);
        check(d, 16'h000A);
        brownout(n);
        // Counts start as the reset pulse ends, one cycle into the hold
        wait_sig(SC, 1'b1, 40, 1'b1, n);
        check(b(n >= OSC_STARTUP_TIMER - 1 && n <= OSC_STARTUP_TIMER + 2), 16'h0001);
        wait_sig(CR, 1'b1, 80, 1'b1, m);
        check(b(n + m >= FIXED && n + m <= FIXED + 6), 16'h0001);
        // Start-up timer done clears once the hold is over
        rd(`BRS_REG_OSC, d);
        check(d & 16'h000F, 16'h0002);
        rd(`BRS_REG_CAUSE, d);
        check(d & 16'h0002, 16'h0002);
        // Flag survives the reset it reports, cleared by writing one
        rd(`BRS_REG_CAUSE, d);
        check(d & 16'h0002, 16'h0002);
        wr(`BRS_REG_CAUSE, 16'h0002);
        rd(`BRS_REG_CAUSE, d);
        check(d, 16'h0001);
        // Power-up timer holds the internal reset
        wr(`BRS_REG_CFG, 16'h0020);
        brownout(n);
        wait_sig(CR, 1'b1, 80, 1'b1, n);
        check(b(n >= POWERUP_TIMER && n <= POWERUP_TIMER + 6), 16'h0001);
        // PLL in use: clock waits for lock
        wr(`BRS_REG_CFG, 16'h0021);
        brownout(n);
        wait_sig(SC, 1'b1, 120, 1'b1, n);
        check(b(n >= LOCK), 16'h0001);
        wait_sig(CR, 1'b1, 40, 1'b1, n);
        rd(`BRS_REG_OSC, d);
        check(d & 16'h0030, 16'h0030);
        // Power-down: detector edges ignored, start-up hold again
        @(posedge mclk);
        powered_down <= 1'b1;
        wait_sig(CR, 1'b0, 8, 1'b1, n);
        brownout_det <= 1'b1;
        wait_sig(BP, 1'b1, 10, 1'b0, n);
        check(b(n == 10), 16'h0001);
        brownout_det <= 1'b0;
        powered_down <= 1'b0;
        wait_sig(CR, 1'b1, 120, 1'b1, n);
        check(b(n >= STARTUP), 16'h0001);
        end_sim();
    end

endmodule : tb_brs_sequencer

`default_nettype wire
